// ### core/fir_cycle_timer.v
/*
  small down-counter that times one phase of a flash bus cycle.
  assumes load is a one-cycle pulse; done is high in the cycle the count
  reaches zero and stays high until the next load.
*/
`timescale 1ns/1ps
module fir_cycle_timer #(
  parameter W = 12
) (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [W-1:0] count,
  output wire done
);
  reg [W-1:0] cnt_q; // remaining cycles
  // count down to zero after each load
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  // done looks at the count only: callers derive load from done, so
  // folding load back in here would close a combinational loop
  assign done = (cnt_q == {W{1'b0}});
endmodule

// ### core/fir_host.v
/*
  host controller for a parallel flash's info-read commands: writes command
  bytes and reads identifier, status, extended status and query data.
  software drives it over classic wishbone; the flash sits on the pins.
  assumes the flash pins are synchronous to CLK.
*/
// Implementation choice: the Wishbone slave port.
// Operation
// - after id command reads return identifier
// - status latched on strobe fall, release between
// - multi-write command shows extended status
// - query block status valid only when ready
`timescale 1ns/1ps
`include "fir_regs.vh"
module fir_host #(
  parameter AW = 22,
  parameter RESET_CYC = `FIR_RESET_CYC
) (
  input wire CLK,
  input wire RSTN,
  input wire [3:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  input wire WB_WE_I,
  input wire [3:0] WB_SEL_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  output reg WB_ACK_O,
  output reg [AW-1:0] FL_ADDR,
  input wire [15:0] FL_DQ_I,
  output reg [15:0] FL_DQ_O,
  output reg FL_DQ_OE,
  output reg FL_CE_N,
  output reg FL_OE_N,
  output reg FL_WE_N,
  output reg FL_BYTE_N,
  output reg FL_POWERDOWN_RESET_N
);
  // one-hot states of the bus sequencer
  localparam S_IDLE = 7'h01;
  localparam S_WSET = 7'h02;
  localparam S_WREC = 7'h04;
  localparam S_RSTR = 7'h08;
  localparam S_RREC = 7'h10;
  localparam S_RST = 7'h20;
  localparam S_WGAP = 7'h40;
  localparam [11:0] PULSE_C = `FIR_PULSE_CYC;
  localparam [11:0] READ_C = `FIR_READ_CYC;
  localparam [11:0] REC_C = `FIR_RECOVER_CYC;

  reg [6:0] st_q; // sequencer state
  reg [2:0] op_q; // pending host op
  reg [7:0] cmd_q; // command byte to write
  reg byte_mode_q; // byte-wide bus selected
  reg [AW-1:0] addr_q; // read address from software
  reg [15:0] rdata_q; // last data read from flash
  reg busy_q; // sequence running
  reg [7:0] mode_q; // last command written, tracks flash read mode
  reg [19:0] rst_cnt_q; // reset pulse length counter
  reg tload; // timer load pulse
  reg [11:0] tcount; // timer load value
  wire tdone; // phase elapsed
  wire wb_req; // classic wishbone strobe

  fir_cycle_timer #(.W(12)) u_timer (
    .clk(CLK),
    .rst_n(RSTN),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );

  // query address: in byte mode a0 does not select data, so the word
  // offset is shifted up and a0 left zero
  function [AW-1:0] qaddr;
    input [AW-1:0] a;
    input bm;
    begin
      qaddr = bm ? {a[AW-2:0], 1'b0} : a;
    end
  endfunction

  assign wb_req = WB_CYC_I && WB_STB_I;

  // timer load is combinational on state entry
  always @* begin
    tload = 1'b0;
    tcount = PULSE_C;
    case (st_q)
      S_IDLE: begin
        tload = busy_q && (op_q != `FIR_OP_RESET);
        tcount = (op_q == `FIR_OP_READ) ? READ_C : PULSE_C;
      end
      S_WSET: begin
        tload = tdone;
        tcount = REC_C;
      end
      S_WGAP: begin
        tload = tdone;
        tcount = READ_C;
      end
      S_RSTR: begin
        tload = tdone;
        tcount = REC_C;
      end
      default: begin
        tload = 1'b0;
        tcount = PULSE_C;
      end
    endcase
  end

  // wishbone slave: one wait state, ack drops the cycle after
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      op_q <= 3'h0;
      cmd_q <= `FIR_CMD_READ_ARRAY;
      byte_mode_q <= 1'b0;
      addr_q <= {AW{1'b0}};
      busy_q <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req && !WB_ACK_O;
      if (wb_req && !WB_ACK_O) begin
        if (WB_WE_I) begin
          case (WB_ADR_I)
            `FIR_REG_CTRL: begin
              // a go while busy is dropped; software polls busy first
              if (!busy_q && WB_SEL_I[0] &&
                  WB_DAT_I[`FIR_CTRL_GO]) begin
                op_q <= WB_DAT_I[2:0];
                busy_q <= 1'b1;
              end
              if (WB_SEL_I[0] && !busy_q) begin
                byte_mode_q <= WB_DAT_I[`FIR_CTRL_BYTE_MODE];
              end
              if (WB_SEL_I[1] && !busy_q) begin
                cmd_q <= WB_DAT_I[15:8];
              end
            end
            `FIR_REG_ADDR: begin
              if (!busy_q) begin
                addr_q <= WB_DAT_I[AW-1:0];
              end
            end
            default: begin
              addr_q <= addr_q; // read-only or unmapped: ignored
            end
          endcase
        end else begin
          case (WB_ADR_I)
            `FIR_REG_CTRL: WB_DAT_O <= {16'h0000, cmd_q, 2'b00,
              byte_mode_q, busy_q, 1'b0, op_q};
            `FIR_REG_ADDR: WB_DAT_O <= {{(32-AW){1'b0}}, addr_q};
            `FIR_REG_DATA: WB_DAT_O <= {16'h0000, rdata_q};
            `FIR_REG_STAT: WB_DAT_O <= {23'h000000, busy_q, mode_q};
            default: WB_DAT_O <= 32'h00000000;
          endcase
        end
      end
      if (busy_q && st_q == S_IDLE && op_q == 3'h0) begin
        busy_q <= 1'b0;
      end
      if (st_q == S_WREC && tdone && op_q != `FIR_OP_CMD_READ) begin
        busy_q <= 1'b0;
      end
      if (st_q == S_WREC && tdone && op_q == `FIR_OP_CMD_READ) begin
        op_q <= `FIR_OP_READ;
      end
      if ((st_q == S_RREC && tdone) ||
          (st_q == S_RST && rst_cnt_q == 20'h00000)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // flash bus sequencer
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= S_IDLE;
      FL_ADDR <= {AW{1'b0}};
      FL_DQ_O <= 16'h0000;
      FL_DQ_OE <= 1'b0;
      FL_CE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_BYTE_N <= 1'b1;
      FL_POWERDOWN_RESET_N <= 1'b1;
      rdata_q <= 16'h0000;
      mode_q <= `FIR_CMD_READ_ARRAY;
      rst_cnt_q <= 20'h00000;
    end else begin
      FL_BYTE_N <= !byte_mode_q;
      case (st_q)
        S_IDLE: begin
          if (busy_q && op_q == `FIR_OP_RESET) begin
            FL_POWERDOWN_RESET_N <= 1'b0;
            rst_cnt_q <= RESET_CYC[19:0];
            st_q <= S_RST;
          end else if (busy_q && op_q == `FIR_OP_READ) begin
            // status latches on this fall; fresh each read
            FL_ADDR <= (mode_q == `FIR_CMD_QUERY) ?
              qaddr(addr_q, byte_mode_q) : addr_q;
            FL_CE_N <= 1'b0;
            FL_OE_N <= 1'b0;
            st_q <= S_RSTR;
          end else if (busy_q && op_q != 3'h0) begin
            // address is don't-care for info commands
            FL_DQ_O <= {8'h00, cmd_q};
            FL_DQ_OE <= 1'b1;
            FL_CE_N <= 1'b0;
            FL_WE_N <= 1'b0;
            st_q <= S_WSET;
          end
        end
        S_WSET: begin
          if (tdone) begin
            // flash captures on this rising edge of the write strobe
            FL_WE_N <= 1'b1;
            FL_CE_N <= 1'b1;
            mode_q <= cmd_q;
            st_q <= S_WREC;
          end
        end
        S_WREC: begin
          FL_DQ_OE <= 1'b0;
          if (tdone) begin
            st_q <= S_WGAP;
          end
        end
        S_WGAP: begin
          if (op_q == `FIR_OP_READ) begin
            FL_ADDR <= (mode_q == `FIR_CMD_QUERY) ?
              qaddr(addr_q, byte_mode_q) : addr_q;
            FL_CE_N <= 1'b0;
            FL_OE_N <= 1'b0;
            st_q <= S_RSTR;
          end else begin
            st_q <= S_IDLE;
          end
        end
        S_RSTR: begin
          if (tdone) begin
            // query data sits on the low lines; high lines are zero
            rdata_q <= (mode_q == `FIR_CMD_QUERY) ?
            // block status is only meaningful when the flash is ready;
            // software polls the ready flag before this read
              {8'h00, FL_DQ_I[7:0]} : FL_DQ_I;
            FL_OE_N <= 1'b1;
            FL_CE_N <= 1'b1;
            st_q <= S_RREC;
          end
        end
        S_RREC: begin
          if (tdone) begin
            st_q <= S_IDLE;
          end
        end
        S_RST: begin
          if (rst_cnt_q == 20'h00000) begin
            FL_POWERDOWN_RESET_N <= 1'b1;
            mode_q <= `FIR_CMD_READ_ARRAY;
            st_q <= S_IDLE;
          end else begin
            rst_cnt_q <= rst_cnt_q - 20'h00001;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ### core/fir_regs.vh
/*
  constants for the flash info-read host controller: command opcodes,
  register offsets of the wishbone slave, field positions, timing counts.
  assumes a 10 MHz controller clock (100 ns period).
*/
`ifndef FIR_REGS_VH
`define FIR_REGS_VH
// flash command bytes
`define FIR_CMD_READ_ARRAY 8'hff
`define FIR_CMD_READ_ID 8'h90
`define FIR_CMD_QUERY 8'h98
`define FIR_CMD_READ_STATUS 8'h70
`define FIR_CMD_CLEAR_STATUS 8'h50
`define FIR_CMD_MULTI_WRITE 8'he8
// identifier and query addresses
`define FIR_ID_MFR_ADDR 22'h000000
`define FIR_ID_DEV_ADDR 22'h000002
`define FIR_ID_BLK_OFS 22'h000004
`define FIR_QRY_BLK_OFS 22'h000002
// status register and block status field positions
`define FIR_SR_READY 7
`define FIR_SR_FAIL5 5
`define FIR_SR_FAIL4 4
`define FIR_SR_FAIL3 3
`define FIR_SR_FAIL1 1
`define FIR_BS_LOCK 0
`define FIR_BS_ERASE 1
// wishbone register byte offsets
`define FIR_REG_CTRL 4'h0
`define FIR_REG_ADDR 4'h4
`define FIR_REG_DATA 4'h8
`define FIR_REG_STAT 4'hc
// ctrl register fields
`define FIR_CTRL_OP_LSB 0
`define FIR_CTRL_GO 4
`define FIR_CTRL_BYTE_MODE 5
`define FIR_CTRL_CMD_LSB 8
// host op codes
`define FIR_OP_CMD 3'h1
`define FIR_OP_READ 3'h2
`define FIR_OP_CMD_READ 3'h3
`define FIR_OP_RESET 3'h4
// timing (ns) and derived cycles at 100 ns
`define FIR_CLK_NS 100
`define FIR_T_PULSE_NS 100
`define FIR_T_READ_NS 150
`define FIR_T_RECOVER_NS 100
`define FIR_T_RESET_NS 100000
`define FIR_PULSE_CYC \
  ((`FIR_T_PULSE_NS + `FIR_CLK_NS - 1) / `FIR_CLK_NS)
`define FIR_READ_CYC \
  ((`FIR_T_READ_NS + `FIR_CLK_NS - 1) / `FIR_CLK_NS)
`define FIR_RECOVER_CYC \
  ((`FIR_T_RECOVER_NS + `FIR_CLK_NS - 1) / `FIR_CLK_NS)
`define FIR_RESET_CYC \
  ((`FIR_T_RESET_NS + `FIR_CLK_NS - 1) / `FIR_CLK_NS)
`endif

// ### tb/fir_flash_model.sv
/* behavioural flash answering identifier, status, extended status and
   query reads. assumes pins change just after rising edges of clk. */
`timescale 1ns/1ps
module fir_flash_model #(
  parameter MFR = 8'h5a, // arbitrary maker code
  parameter DEV = 8'ha5 // arbitrary part code
) (
  input wire clk,
  input wire busy,
  input wire [21:0] addr,
  input wire [15:0] din,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire byte_n,
  input wire rp_n,
  output wire [15:0] dout
);
  reg [7:0] mode_q = 8'hff; // comes up in array read
  reg [7:0] fail_q = 8'h3a; // failure bits preset to show stickiness
  reg [15:0] hold_q = 16'h0; // data latched at the read strobe fall
  reg ce_q = 1'b1, oe_q = 1'b1, we_q = 1'b1; // pin values one edge ago
  wire [7:0] sr = {~busy, fail_q[6:0]}; // ready flag low while busy
  wire [21:0] qa = byte_n ? addr : addr >> 1;
  reg [15:0] val;
  // answer selected by the current read mode
  always @* begin
    case (mode_q)
      8'h90: val = addr[3:0] < 2 ? MFR : addr[3:0] < 4 ? DEV :
        addr[3:0] < 6 ? 16'h3 : 16'h0; // locked, erase failed
      8'h70: val = {8'h0, sr};
      8'he8: val = 16'h0080; // buffer available
      8'h98: val = qa[4:0] == 5'h2 ? 16'h3 :
        qa[4:0] == 5'h10 ? 16'h51 : 16'h0;
      default: val = addr[15:0] ^ 16'h5a5a;
    endcase
  end
  // commands latch when either strobe rises out of a write
  always @(posedge clk) begin
    ce_q <= ce_n;
    oe_q <= oe_n;
    we_q <= we_n;
    if (!rp_n) begin
      mode_q <= 8'hff;
    end else if (!ce_q && !we_q && (ce_n || we_n)) begin
      if (din[7:0] == 8'h50) begin
        if (!busy) fail_q <= 8'h0;
      end else begin
        mode_q <= din[7:0];
      end
    end
    if (!ce_n && !oe_n && (ce_q || oe_q)) hold_q <= val;
  end
  // released bus shows inverted data, never a stale match
  assign dout = (!ce_n && !oe_n) ? hold_q : ~hold_q;
endmodule

// ### tb/fir_host_sva.sv
/* pin-level checks for the flash info-read host controller.
   assumes it is bound to fir_host and sees only its ports. */
`timescale 1ns/1ps
module fir_host_sva (
  input wire CLK,
  input wire RSTN,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_ACK_O,
  input wire FL_DQ_OE,
  input wire FL_CE_N,
  input wire FL_OE_N,
  input wire FL_WE_N,
  input wire FL_POWERDOWN_RESET_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // a taken request is answered on the very next edge
  AST_ACK_ONE: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack did not follow request");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack stood two cycles");
  // strobes rise together so the latch edge is unambiguous
  AST_WE_CE: assert property ($rose(FL_WE_N) |-> $rose(FL_CE_N))
    else $error("write strobe rose apart from chip select");
  AST_DQ_DRIVE: assert property (!FL_WE_N |-> FL_DQ_OE)
    else $error("command byte not driven during write");
  AST_WE_HOLD: assert property ($rose(FL_WE_N) |-> FL_DQ_OE)
    else $error("data released before latch edge");
  AST_NO_OE_WE: assert property (!(!FL_OE_N && !FL_WE_N))
    else $error("read and write strobes low together");
  // three cycles low, then high again so the next fall relatches
  AST_RD_LEN: assert property ($fell(FL_OE_N) |=>
    !FL_OE_N ##1 !FL_OE_N ##1 FL_OE_N)
    else $error("read strobe length wrong");
  AST_RD_CE: assert property (!FL_OE_N |-> !FL_CE_N && !FL_DQ_OE)
    else $error("read without select or with bus driven");
  AST_RESET_PIN: assert property (!FL_POWERDOWN_RESET_N |-> FL_CE_N)
    else $error("flash selected while held in power-down");
endmodule
bind fir_host fir_host_sva chk (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .FL_DQ_OE(FL_DQ_OE),
  .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
  .FL_POWERDOWN_RESET_N(FL_POWERDOWN_RESET_N));

// ### tb/testbench.sv
/* self-checking bench: wishbone tasks drive fir_host against the flash
   model. assumes a 100 ns clock and a shortened reset pulse. */
`timescale 1ns/1ps
`include "fir_regs.vh"
module testbench;
  localparam MFR = 8'h5a; // arbitrary maker code
  localparam DEV = 8'ha5; // arbitrary part code
  reg clk, rstn, cyc, we, busy;
  reg [3:0] adr;
  reg [31:0] wdat, rd;
  wire [31:0] dat_o;
  wire ack, oe, ce_n, oe_n, we_n, byte_n, rp_n;
  wire [21:0] fa;
  wire [15:0] dq_o, dq_i;
  integer fail_count = 0, total_checks = 0, i;
  fir_host #(.RESET_CYC(4)) uut (.CLK(clk), .RSTN(rstn), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_WE_I(we), .WB_SEL_I(4'hf),
    .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_ACK_O(ack), .FL_ADDR(fa),
    .FL_DQ_I(dq_i), .FL_DQ_O(dq_o), .FL_DQ_OE(oe), .FL_CE_N(ce_n),
    .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_BYTE_N(byte_n),
    .FL_POWERDOWN_RESET_N(rp_n));
  fir_flash_model #(.MFR(MFR), .DEV(DEV)) fl (.clk(clk), .busy(busy),
    .addr(fa), .din(dq_o), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .byte_n(byte_n), .rp_n(rp_n), .dout(dq_i));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one classic cycle; request held until ack is sampled
  task wb(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      rd = dat_o;
      cyc <= 1'b0;
      we <= 1'b0;
    end
  endtask
  // start a flash operation, poll busy, fetch the data word
  task op(input [7:0] c, input [2:0] o, input [21:0] a, input bm);
    begin
      wb(1'b1, `FIR_REG_ADDR, {10'h0, a});
      wb(1'b1, `FIR_REG_CTRL, {16'h0, c, 2'b0, bm, 2'b10, o});
      rd = 32'h100;
      while (rd[8] !== 1'b0) wb(1'b0, `FIR_REG_STAT, 32'h0);
      wb(1'b0, `FIR_REG_DATA, 32'h0);
    end
  endtask
  task rdchk(input [21:0] a, input bm, input [15:0] exp);
    begin
      op(8'h0, `FIR_OP_READ, a, bm);
      check(rd[15:0], exp);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #(100 * 30000);
    fail_count = fail_count + 1;
    end_of_test;
  end
  initial begin
    rstn = 0; cyc = 0; we = 0; busy = 0; adr = 0; wdat = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, 4'h2, 32'hffff); check(rd, 32'h0); // unmapped reads zero
    rdchk(22'h10, 1'b0, 16'h0010 ^ 16'h5a5a);
    $display("array test done");
    op(`FIR_CMD_READ_ID, `FIR_OP_CMD, 22'h0, 1'b0);
    for (i = 0; i < 6; i = i + 1) begin
      rdchk(i[21:0], 1'b0,
        i < 2 ? MFR : i < 4 ? DEV : 16'h3);
    end
    $display("identifier test done");
    busy <= 1'b1;
    op(`FIR_CMD_READ_STATUS, `FIR_OP_CMD_READ, 22'h0, 1'b0);
    check(rd[15:0], 16'h003a);
    op(`FIR_CMD_CLEAR_STATUS, `FIR_OP_CMD, 22'h0, 1'b0); // ignored while busy
    busy <= 1'b0;
    rdchk(22'h7, 1'b0, 16'h00ba);
    op(`FIR_CMD_CLEAR_STATUS, `FIR_OP_CMD, 22'h0, 1'b0);
    wb(1'b0, `FIR_REG_STAT, 32'h0); check(rd[7:0], 8'h50);
    rdchk(22'h0, 1'b0, 16'h0080);
    $display("status test done");
    op(`FIR_CMD_MULTI_WRITE, `FIR_OP_CMD_READ, 22'h0, 1'b0);
    check(rd[15:0], 16'h0080);
    op(`FIR_CMD_QUERY, `FIR_OP_CMD_READ, 22'h2, 1'b0);
    check(rd[15:0], 16'h0003);
    rdchk(22'h10, 1'b0, 16'h0051);
    rdchk(22'h5, 1'b0, 16'h0000);
    rdchk(22'h10, 1'b1, 16'h0051);
    rdchk(22'h2, 1'b1, 16'h0003);
    $display("query test done");
    op(8'h0, `FIR_OP_RESET, 22'h0, 1'b0);
    wb(1'b0, `FIR_REG_STAT, 32'h0); check(rd[7:0], 8'hff);
    rdchk(22'h22, 1'b0, 16'h0022 ^ 16'h5a5a);
    $display("reset test done");
    end_of_test;
  end
endmodule
